/* include/indexed_access_pkg.sv */
// Package with the port addresses, index layout, reset values and bit-type masks of the access core.
package indexed_access_pkg;

    // Host I/O port addresses.
    localparam logic [9:0] INDEX_PORT_ADDR = 10'h3E0;
    localparam logic [9:0] DATA_PORT_ADDR  = 10'h3E1;

    // Index pointer layout and reset value.
    localparam int         REG_PTR_MSB        = 5;
    localparam int         SOCKET_BIT_POS     = 6;
    localparam int         CHIP_BIT_POS       = 7;
    localparam logic [7:0] INDEX_RESET        = 8'h00;
    localparam logic [7:0] SOCKET_STRIDE      = 8'h40;
    localparam int         REGS_PER_SOCKET    = 64;

    // Implemented internal registers (socket A index; socket B adds the stride).
    localparam logic [5:0] REG_IDENT          = 6'h00;
    localparam logic [5:0] REG_STATUS         = 6'h01;
    localparam logic [5:0] REG_CONTROL        = 6'h02;
    localparam logic [5:0] REG_EVENT          = 6'h04;
    localparam logic [5:0] REG_SCRATCH        = 6'h16;
    localparam logic [5:0] REG_CHIP_CONFIG    = 6'h1E;

    // Reset values.
    localparam logic [7:0] CONTROL_RESET      = 8'h00;
    localparam logic [7:0] SCRATCH_RESET      = 8'h00;
    localparam logic [7:0] CHIP_CONFIG_RESET  = 8'h00;
    localparam logic [7:0] EVENT_RESET        = 8'h00;

    // Identification value is arbitrary.
    localparam logic [7:0] IDENT_VALUE        = 8'h5A;

    // Control register: bit 0 enable, bit 1 disable, bits 3:2 output field, bit 7 compatibility.
    localparam int         CTRL_ENABLE_POS    = 0;
    localparam int         CTRL_DISABLE_POS   = 1;
    localparam int         CTRL_OUT_LSB       = 2;
    localparam logic [7:0] CONTROL_WMASK      = 8'h8F;
    // Status register: bits 1:0 input field, bit 6 fixed one, bit 7 response-select bit.
    localparam logic [7:0] STATUS_FIXED       = 8'h40;
    // Chip configuration: bits 3:0 read/write, bits 7:4 also read/write and stored as written.
    localparam logic [7:0] CHIP_CONFIG_WMASK  = 8'hFF;

    // One host I/O cycle as seen at the pins.
    typedef struct packed {
        logic [9:0] addr;
        logic       rd;
        logic       wr;
        logic       hi_byte;
        logic [7:0] wdata;
    } io_cycle_t;

    // Per-socket register state.
    typedef struct packed {
        logic [7:0] control;
        logic [7:0] event_flags;
        logic [7:0] scratch;
    } socket_regs_t;

endpackage

/* logic/socket_bank.sv */
// One socket's copy of the per-socket registers.
`timescale 1ns/1ps
module socket_bank
    import indexed_access_pkg::*;
(
    // Clock and resets
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         pg_reload,
    // Register access
    input  wire logic         wr_en,
    input  wire logic [5:0]   reg_sel,
    input  wire logic [7:0]   wdata,
    // Hardware events and state
    input  wire logic [7:0]   event_set,
    output socket_regs_t      regs
);

    socket_regs_t next_regs;

    always_comb begin
        next_regs = regs;
        if (wr_en) begin
            unique case (reg_sel)
                REG_CONTROL: next_regs.control = wdata & CONTROL_WMASK;
                // Writing one clears a flag; a write can never set one.
                REG_EVENT:   next_regs.event_flags = regs.event_flags & ~wdata;
                REG_SCRATCH: next_regs.scratch = wdata;
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle.
        next_regs.event_flags = next_regs.event_flags | event_set;
        if (pg_reload) begin
            next_regs.control     = CONTROL_RESET;
            next_regs.scratch     = SCRATCH_RESET;
            next_regs.event_flags = EVENT_RESET | event_set;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regs.control     <= CONTROL_RESET;
            regs.event_flags <= EVENT_RESET;
            regs.scratch     <= SCRATCH_RESET;
        end else begin
            regs <= next_regs;
        end
    end

endmodule // socket_bank

/* logic/indexed_register_access_core.sv */
// Index and data window front end with chip and socket register banks.
`timescale 1ns/1ps
module indexed_register_access_core
    import indexed_access_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         power_good_input,
    // Host I/O cycle
    input  io_cycle_t         io,
    output logic [7:0]        rdata,
    output logic              rdata_oe,
    // Strap and identity
    input  wire logic         socket_response_select_pin,
    input  wire logic         chip_id,
    // Socket pins
    input  wire logic [1:0]   socket_a_inputs,
    input  wire logic [1:0]   socket_b_inputs,
    input  wire logic [7:0]   socket_a_events,
    input  wire logic [7:0]   socket_b_events,
    output logic [1:0]        socket_a_outputs,
    output logic [1:0]        socket_b_outputs,
    output logic              socket_a_active,
    output logic              socket_b_active,
    output logic              response_socket
);

    logic [7:0]   index_pointer;
    logic [7:0]   next_index_pointer;
    logic [7:0]   chip_config;
    logic [7:0]   next_chip_config;
    logic         strap_pending;
    logic         next_strap_pending;
    logic         next_response_socket;
    logic         pg_last;
    logic         next_pg_last;
    logic         pg_reload;
    logic [7:0]   next_rdata;
    logic         next_rdata_oe;
    logic         index_hit;
    logic         data_hit;
    logic         chip_match;
    logic         socket_sel;
    logic [5:0]   reg_sel;
    logic         wr_a;
    logic         wr_b;
    socket_regs_t regs_a;
    socket_regs_t regs_b;
    socket_regs_t regs_sel;
    logic [1:0]   inputs_sel;

    // Decodes a host address against one port.
    function automatic logic port_hit(input logic [9:0] addr, input logic [9:0] port);
        port_hit = (addr == port);
    endfunction

    // Status register content: strap bit, fixed one, sampled inputs.
    function automatic logic [7:0] status_word(input logic strap, input logic [1:0] pins);
        status_word = STATUS_FIXED | {strap, 5'h00, pins};
    endfunction

    // True when a host cycle writes the data window of this chip.
    function automatic logic window_write(input io_cycle_t cyc, input logic hit, input logic match);
        window_write = cyc.wr & hit & match;
    endfunction

    // Enable bit acts when high, disable bit acts when high and overrides enable.
    function automatic logic socket_enabled(input logic [7:0] control);
        socket_enabled = control[CTRL_ENABLE_POS] & ~control[CTRL_DISABLE_POS];
    endfunction

    // Chip 0 owns the low lane of the index port, chip 1 only the upper lane.
    function automatic logic index_lane_owned(input logic chip, input logic upper);
        index_lane_owned = (chip == 1'b0) ? ~upper : upper;
    endfunction

    assign index_hit  = port_hit(io.addr, INDEX_PORT_ADDR);
    assign data_hit   = port_hit(io.addr, DATA_PORT_ADDR);
    assign reg_sel    = index_pointer[REG_PTR_MSB:0];
    assign socket_sel = index_pointer[SOCKET_BIT_POS];
    assign chip_match = (index_pointer[CHIP_BIT_POS] == chip_id);
    // Power-good rising edge reloads the read/write and read-only defaults.
    assign pg_reload  = power_good_input & ~pg_last;

    // Each data write to this chip reaches exactly one socket's copy.
    assign wr_a = window_write(io, data_hit, chip_match) & ~socket_sel;
    assign wr_b = window_write(io, data_hit, chip_match) & socket_sel;

    socket_bank bank_a (
        .clk       (clk),
        .rst       (rst),
        .pg_reload (pg_reload),
        .wr_en     (wr_a),
        .reg_sel   (reg_sel),
        .wdata     (io.wdata),
        .event_set (socket_a_events),
        .regs      (regs_a)
    );

    socket_bank bank_b (
        .clk       (clk),
        .rst       (rst),
        .pg_reload (pg_reload),
        .wr_en     (wr_b),
        .reg_sel   (reg_sel),
        .wdata     (io.wdata),
        .event_set (socket_b_events),
        .regs      (regs_b)
    );

    assign regs_sel   = socket_sel ? regs_b : regs_a;
    assign inputs_sel = socket_sel ? socket_b_inputs : socket_a_inputs;

    // Index pointer.
    always_comb begin
        next_index_pointer = index_pointer;
        // An upper-lane write to the index port carries no pointer byte.
        if (io.wr && index_hit && !io.hi_byte) begin
            next_index_pointer = io.wdata;
        end
        if (pg_reload) begin
            next_index_pointer = INDEX_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index_pointer <= INDEX_RESET;
        end else begin
            index_pointer <= next_index_pointer;
        end
    end

    // Chip registers exist once, reached from either socket index.
    always_comb begin
        next_chip_config = chip_config;
        if (window_write(io, data_hit, chip_match) && reg_sel == REG_CHIP_CONFIG) begin
            next_chip_config = io.wdata & CHIP_CONFIG_WMASK;
        end
        if (pg_reload) begin
            next_chip_config = CHIP_CONFIG_RESET;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_config <= CHIP_CONFIG_RESET;
        end else begin
            chip_config <= next_chip_config;
        end
    end

    // Power-good edge detector.
    always_comb begin
        next_pg_last = power_good_input;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Starts high, so a supply that is already good at reset release gives no false reload.
            pg_last <= 1'b1;
        end else begin
            pg_last <= next_pg_last;
        end
    end

    // The strap is caught on the first edge after reset release, never by the reset itself.
    always_comb begin
        next_strap_pending   = 1'b0;
        next_response_socket = response_socket;
        if (strap_pending) begin
            next_response_socket = socket_response_select_pin;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strap_pending   <= 1'b1;
            response_socket <= 1'b0;
        end else begin
            strap_pending   <= next_strap_pending;
            response_socket <= next_response_socket;
        end
    end

    // Read data path.
    always_comb begin
        next_rdata    = 8'h00;
        next_rdata_oe = 1'b0;
        if (io.rd && index_hit) begin
            // Only chip 0 answers a low-byte index read; chip 1 only drives the upper byte of a word read.
            if (index_lane_owned(chip_id, io.hi_byte)) begin
                next_rdata    = index_pointer;
                next_rdata_oe = 1'b1;
            end
        end else if (io.rd && data_hit && chip_match) begin
            next_rdata_oe = 1'b1;
            unique case (reg_sel)
                REG_IDENT:       next_rdata = IDENT_VALUE;
                REG_STATUS:      next_rdata = status_word(response_socket, inputs_sel);
                REG_CONTROL:     next_rdata = regs_sel.control;
                REG_EVENT:       next_rdata = regs_sel.event_flags;
                REG_SCRATCH:     next_rdata = regs_sel.scratch;
                REG_CHIP_CONFIG: next_rdata = chip_config;
                default:         next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata    <= 8'h00;
            rdata_oe <= 1'b0;
        end else begin
            rdata    <= next_rdata;
            rdata_oe <= next_rdata_oe;
        end
    end

    // Control bit 7 is a compatibility bit: stored, read back, drives nothing.
    always_comb begin
        socket_a_active  = socket_enabled(regs_a.control);
        socket_b_active  = socket_enabled(regs_b.control);
        socket_a_outputs = regs_a.control[CTRL_OUT_LSB +: 2];
        socket_b_outputs = regs_b.control[CTRL_OUT_LSB +: 2];
    end

endmodule // indexed_register_access_core

/* tb/access_checker_assertions.sv */
// Port-level assertions for the indexed register access core.
`timescale 1ns/1ps
module access_checker
    import indexed_access_pkg::*;
(
    // Clock and resets
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       power_good_input,
    // Host cycle
    input  io_cycle_t       io,
    input  wire logic [7:0] rdata,
    input  wire logic       rdata_oe,
    // Straps and socket pins
    input  wire logic       socket_response_select_pin,
    input  wire logic       chip_id,
    input  wire logic [1:0] socket_a_outputs,
    input  wire logic       socket_a_active,
    input  wire logic       response_socket
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_idx_wr;
        io.wr && io.addr == INDEX_PORT_ADDR && !io.hi_byte;
    endsequence
    sequence s_idx_rd;
        io.rd && io.addr == INDEX_PORT_ADDR && !io.hi_byte && !chip_id;
    endsequence
    property p_oe_cause;
        rdata_oe |-> $past(io.rd) && ($past(io.addr) == INDEX_PORT_ADDR || $past(io.addr) == DATA_PORT_ADDR);
    endproperty
    property p_write_silent;
        io.wr && !io.rd |=> !rdata_oe;
    endproperty
    property p_idx_echo;
        s_idx_wr ##1 !io.wr ##1 s_idx_rd |=> rdata_oe && rdata == $past(io.wdata, 3);
    endproperty
    property p_chip1_low;
        chip_id && io.rd && io.addr == INDEX_PORT_ADDR && !io.hi_byte |=> !rdata_oe;
    endproperty
    property p_strap_capture;
        $past(rst) |=> response_socket == $past(socket_response_select_pin);
    endproperty
    // The capture edge itself changes the bit, so the hold check starts one edge later.
    property p_strap_hold;
        !$past(rst) && !$past(rst, 2) |-> $stable(response_socket);
    endproperty
    property p_pg_reload;
        $rose(power_good_input) |-> ##[1:3] (socket_a_outputs == 2'b00 && !socket_a_active);
    endproperty
    property p_outs_hold;
        !$past(io.wr) && $past(power_good_input) && $past(power_good_input, 2) && $past(power_good_input, 3)
            |-> $stable(socket_a_outputs) && $stable(socket_a_active);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("read enable without port read");
    a_write_silent: assert property (p_write_silent) else $error("write drove read data");
    a_idx_echo: assert property (p_idx_echo) else $error("pointer readback wrong");
    a_chip1_low: assert property (p_chip1_low) else $error("second chip drove low pointer byte");
    a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");
    a_strap_hold: assert property (p_strap_hold) else $error("strap bit changed");
    a_pg_reload: assert property (p_pg_reload) else $error("outputs kept after power good");
    a_outs_hold: assert property (p_outs_hold) else $error("outputs moved without write");
endmodule // access_checker

/* tb/host_model.sv */
// Host processor model that issues single-byte port cycles.
`timescale 1ns/1ps
module host_model
    import indexed_access_pkg::*;
(
    // Clock and read return
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    input  wire logic       rdata_oe,
    // Host cycle
    output io_cycle_t       io
);
    initial io = '0;
    // Released address and data lines flip rather than hold and the strobes drop low, so stale values never look valid.
    task automatic release_bus();
        io = '{addr: ~io.addr, rd: 1'b0, wr: 1'b0, hi_byte: 1'b0, wdata: ~io.wdata};
    endtask
    task automatic io_write(input logic [9:0] a, input logic [7:0] d);
        @(negedge clk);
        io = '{addr: a, rd: 1'b0, wr: 1'b1, hi_byte: 1'b0, wdata: d};
        @(negedge clk);
        release_bus();
    endtask
    task automatic io_read(input logic [9:0] a, input logic hi, output logic [7:0] d, output logic oe);
        @(negedge clk);
        io = '{addr: a, rd: 1'b1, wr: 1'b0, hi_byte: hi, wdata: ~io.wdata};
        @(negedge clk);
        d = rdata;
        oe = rdata_oe;
        release_bus();
    endtask
endmodule // host_model

/* tb/tb_top.sv */
// Testbench for the indexed register access core.
`timescale 1ns/1ps
module tb_top;
    import indexed_access_pkg::*;
    logic       clk, rst, pg, strap, chip, rdata_oe, act_a, act_b, resp;
    logic [1:0] in_a, in_b, out_a, out_b;
    logic [7:0] ev_a, ev_b, rdata;
    io_cycle_t  io;
    int         err_total, checks_done;
    host_model host_u (.clk(clk), .rdata(rdata), .rdata_oe(rdata_oe), .io(io));
    indexed_register_access_core dut_u (.clk(clk), .rst(rst), .power_good_input(pg), .io(io), .rdata(rdata),
        .rdata_oe(rdata_oe), .socket_response_select_pin(strap), .chip_id(chip), .socket_a_inputs(in_a),
        .socket_b_inputs(in_b), .socket_a_events(ev_a), .socket_b_events(ev_b), .socket_a_outputs(out_a),
        .socket_b_outputs(out_b), .socket_a_active(act_a), .socket_b_active(act_b), .response_socket(resp));
    task automatic summarize();
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_port(input logic [9:0] a, input logic hi, input logic oe_exp, input logic [7:0] exp);
        logic [7:0] d;
        logic       oe;
        host_u.io_read(a, hi, d, oe);
        check({7'h00, oe}, {7'h00, oe_exp});
        if (oe_exp) begin
            check(d, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        host_u.io_write(INDEX_PORT_ADDR, idx);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, exp);
    endtask
    task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
        host_u.io_write(INDEX_PORT_ADDR, idx);
        host_u.io_write(DATA_PORT_ADDR, d);
    endtask
    task automatic t_reset_state();
        rd_chk(8'h00, IDENT_VALUE);
        rd_chk(8'h02, CONTROL_RESET);
        rd_chk(8'h44, EVENT_RESET);
        rd_chk(8'h01, STATUS_FIXED | 8'h82);
        check({7'h00, resp}, 8'h01);
    endtask
    task automatic t_storage();
        wr_reg(8'h16, 8'hA5);
        wr_reg(8'h56, 8'h3C);
        wr_reg(8'h1E, 8'h0F);
        wr_reg(8'h00, 8'h00);
        wr_reg(8'h41, 8'h00);
        rd_chk(8'h16, 8'hA5);
        rd_chk(8'h56, 8'h3C);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, 8'h3C);
        rd_chk(8'h1E, 8'h0F);
        rd_chk(8'h00, IDENT_VALUE);
        rd_chk(8'h41, STATUS_FIXED | 8'h81);
    endtask
    task automatic t_control();
        wr_reg(8'h02, 8'h8F);
        rd_chk(8'h02, CONTROL_WMASK);
        check({4'h0, out_a, act_a, act_b}, 8'h0C);
        wr_reg(8'h42, 8'h05);
        check({4'h0, out_b, act_b, act_a}, 8'h06);
    endtask
    task automatic t_events();
        @(negedge clk) ev_a = 8'h81;
        @(negedge clk) ev_a = 8'h00;
        rd_chk(8'h04, 8'h81);
        host_u.io_write(DATA_PORT_ADDR, 8'h80);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, 8'h01);
        host_u.io_write(DATA_PORT_ADDR, 8'h7E);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, 8'h01);
        // Event and clear land on one edge: the set must win.
        fork
            host_u.io_write(DATA_PORT_ADDR, 8'h01);
            begin
                @(negedge clk) ev_a = 8'h01;
                @(negedge clk) ev_a = 8'h00;
            end
        join
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, 8'h01);
        host_u.io_write(DATA_PORT_ADDR, 8'h01);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, 8'h00);
    endtask
    task automatic t_index();
        host_u.io_write(INDEX_PORT_ADDR, 8'h43);
        rd_port(INDEX_PORT_ADDR, 1'b0, 1'b1, 8'h43);
        host_u.io_write(DATA_PORT_ADDR, 8'hFF);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, 8'h00);
        host_u.io_write(INDEX_PORT_ADDR, 8'h96);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b0, 8'h00);
        @(negedge clk) chip = 1'b1;
        rd_port(INDEX_PORT_ADDR, 1'b0, 1'b0, 8'h00);
        rd_port(INDEX_PORT_ADDR, 1'b1, 1'b1, 8'h96);
        rd_port(DATA_PORT_ADDR, 1'b0, 1'b1, 8'hA5);
        @(negedge clk) chip = 1'b0;
    endtask
    task automatic t_power_good();
        @(negedge clk) pg = 1'b0;
        repeat (3) @(negedge clk);
        pg = 1'b1;
        repeat (4) @(negedge clk);
        check({2'b00, out_a, out_b, act_a, act_b}, 8'h00);
        rd_port(INDEX_PORT_ADDR, 1'b0, 1'b1, INDEX_RESET);
        rd_chk(8'h16, SCRATCH_RESET);
        rd_chk(8'h1E, CHIP_CONFIG_RESET);
    endtask
    task automatic t_hw_reset();
        wr_reg(8'h56, 8'hC3);
        @(negedge clk) {rst, strap} = 2'b10;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd_chk(8'h56, SCRATCH_RESET);
        rd_chk(8'h01, STATUS_FIXED | 8'h02);
        check({7'h00, resp}, 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #100000;
        err_total++;
        summarize();
    end
    initial begin
        {rst, pg, strap, chip, in_a, in_b, ev_a, ev_b} = {4'b1110, 2'b10, 2'b01, 16'h0000};
        err_total = 0;
        checks_done = 0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_reset_state();
        t_storage();
        t_control();
        t_events();
        t_index();
        t_power_good();
        t_hw_reset();
        summarize();
    end
endmodule // tb_top
bind indexed_register_access_core access_checker chk_u (.clk(clk), .rst(rst), .power_good_input(power_good_input),
    .io(io), .rdata(rdata), .rdata_oe(rdata_oe), .socket_response_select_pin(socket_response_select_pin),
    .chip_id(chip_id), .socket_a_outputs(socket_a_outputs), .socket_a_active(socket_a_active),
    .response_socket(response_socket));
